// ---- cbu_pkg.sv ----
// Package for the conditional branch unit: field layout, opcodes, carriers
package cbu_pkg;
	localparam int CBU_XLEN = 32;
	localparam int CBU_RIDX_W = 5;
	localparam int CBU_RA_HI = 31;
	localparam int CBU_RA_LO = 27;
	localparam int CBU_RB_HI = 26;
	localparam int CBU_RB_LO = 22;
	localparam int CBU_IMM_HI = 21;
	localparam int CBU_IMM_LO = 6;
	localparam int CBU_OP_HI = 5;
	localparam int CBU_OP_LO = 0;
	localparam logic [5:0] CBU_OP_LTU = 6'h36;
	localparam logic [5:0] CBU_OP_NE = 6'h1e;
	localparam logic [31:0] CBU_INSN_STEP = 32'h00000004;
	localparam logic [31:0] CBU_PC_RESET = 32'h00000000;

	// Instruction issued to the unit
	typedef struct packed {
		logic valid;
		logic [31:0] pc;
		logic [31:0] insn;
	} cbu_issue_t;

	// Result handed back to the core
	typedef struct packed {
		logic valid;
		logic is_branch;
		logic taken;
		logic misaligned;
		logic [31:0] next_pc;
	} cbu_result_t;

	typedef enum logic [1:0] {
		CBU_KIND_NONE,
		CBU_KIND_LTU,
		CBU_KIND_NE
	} cbu_kind_t;
endpackage

// ---- cbu_decode.sv ----
// Field decoder for the two I-type compare branches
`timescale 1ns/1ps
module cbu_decode
	import cbu_pkg::*;
(
	input wire logic [31:0] insn_in,
	output cbu_pkg::cbu_kind_t kind_out,
	output logic [4:0] idx_a_out,
	output logic [4:0] idx_b_out,
	output logic [31:0] offset_out
);
	logic [15:0] offset_field;

	// Slice the I-type layout
	always_comb begin
		idx_a_out = insn_in[CBU_RA_HI:CBU_RA_LO];
		idx_b_out = insn_in[CBU_RB_HI:CBU_RB_LO];
		offset_field = insn_in[CBU_IMM_HI:CBU_IMM_LO];
		// Sign extension makes the field a signed byte displacement
		offset_out = {{16{offset_field[15]}}, offset_field};
		case (insn_in[CBU_OP_HI:CBU_OP_LO])
			CBU_OP_LTU: begin
				kind_out = CBU_KIND_LTU;
			end
			CBU_OP_NE: begin
				kind_out = CBU_KIND_NE;
			end
			default: begin
				kind_out = CBU_KIND_NONE;
			end
		endcase
	end
endmodule

// ---- cbu_branch_unit.sv ----
// Conditional branch unit: unsigned less-than and not-equal branches
`timescale 1ns/1ps
module cbu_branch_unit
	import cbu_pkg::*;
(
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic ce_in,
	input wire cbu_pkg::cbu_issue_t issue_in,
	input wire logic [31:0] first_operand_reg_in,
	input wire logic [31:0] second_operand_reg_in,
	output cbu_pkg::cbu_result_t result_out,
	output logic [4:0] rf_idx_a_out,
	output logic [4:0] rf_idx_b_out
);
	import cbu_pkg::*;

	// Whole state in one struct; indices are re-read from each issue, so only the result is kept
	typedef struct packed {
		cbu_result_t res;
	} cbu_state_t;

	cbu_state_t state;
	cbu_state_t next_state;
	cbu_kind_t kind;
	logic [4:0] idx_a;
	logic [4:0] idx_b;
	logic [31:0] offset;
	logic [31:0] seq_pc;
	logic [31:0] target_pc;
	logic cond;

	cbu_decode u_decode (
		.insn_in(issue_in.insn),
		.kind_out(kind),
		.idx_a_out(idx_a),
		.idx_b_out(idx_b),
		.offset_out(offset)
	);

	// Index lookup is combinational; operands must be the values at those indices
	// Left unregistered on purpose: a registered index would cost every branch a stall cycle
	// Limitation: the operand inputs must come from a file that reads without a clock
	assign rf_idx_a_out = idx_a;
	assign rf_idx_b_out = idx_b;

	// Next-state: compare, pick target, check alignment
	always_comb begin
		next_state = state;
		// Both sums wrap at the top of the address space, as the fetch counter does
		seq_pc = issue_in.pc + CBU_INSN_STEP;
		target_pc = seq_pc + offset;
		// Full-width compares, read only
		case (kind)
			CBU_KIND_LTU: begin
				cond = first_operand_reg_in < second_operand_reg_in;
			end
			CBU_KIND_NE: begin
				cond = first_operand_reg_in != second_operand_reg_in;
			end
			default: begin
				cond = 1'b0;
			end
		endcase
		next_state.res.valid = issue_in.valid;
		next_state.res.is_branch = issue_in.valid && (kind != CBU_KIND_NONE);
		next_state.res.taken = next_state.res.is_branch && cond;
		// Choose taken target or fall-through
		next_state.res.next_pc = next_state.res.taken ? target_pc : seq_pc;
		// Only a taken target can be misaligned; a bad offset on a branch not taken is not flagged
		next_state.res.misaligned = next_state.res.taken && (target_pc[1:0] != 2'h0);
	end

	// Register state; ce low freezes everything
	// Reset wins over a low enable, so a stalled core still comes up clean
	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			state <= '0;
			state.res.next_pc <= CBU_PC_RESET;
		end else if (ce_in) begin
			state <= next_state;
		end
	end

	assign result_out = state.res;

	// Checks
	sequence s_taken_ltu;
		issue_in.valid && ce_in && kind == CBU_KIND_LTU && first_operand_reg_in < second_operand_reg_in;
	endsequence

	sequence s_taken_ne;
		issue_in.valid && ce_in && kind == CBU_KIND_NE && first_operand_reg_in != second_operand_reg_in;
	endsequence

	a_ltu_taken_target: assert property (@(posedge clk_in) disable iff (!rstn_in)
		s_taken_ltu |=> result_out.taken && result_out.next_pc == $past(issue_in.pc) + 32'h4 + $past(offset))
		else $error("ltu target wrong");

	a_ne_taken_target: assert property (@(posedge clk_in) disable iff (!rstn_in)
		s_taken_ne |=> result_out.taken && result_out.next_pc == $past(issue_in.pc) + 32'h4 + $past(offset))
		else $error("ne target wrong");

	a_ne_equal_falls: assert property (@(posedge clk_in) disable iff (!rstn_in)
		issue_in.valid && ce_in && kind == CBU_KIND_NE && first_operand_reg_in == second_operand_reg_in
		|=> !result_out.taken && result_out.next_pc == $past(issue_in.pc) + 32'h4)
		else $error("ne fallthrough wrong");

	a_ltu_not_taken: assert property (@(posedge clk_in) disable iff (!rstn_in)
		issue_in.valid && ce_in && kind == CBU_KIND_LTU && first_operand_reg_in >= second_operand_reg_in
		|=> !result_out.taken && result_out.next_pc == $past(issue_in.pc) + 32'h4)
		else $error("ltu fallthrough wrong");

	a_offset_sign_ext: assert property (@(posedge clk_in) disable iff (!rstn_in)
		offset[31:16] == {16{issue_in.insn[21]}} && offset[15:0] == issue_in.insn[21:6])
		else $error("offset extension wrong");

	a_misalign_flag: assert property (@(posedge clk_in) disable iff (!rstn_in)
		result_out.misaligned == (result_out.taken && result_out.next_pc[1:0] != 2'h0))
		else $error("misaligned flag wrong");

	a_opcode_ltu: assert property (@(posedge clk_in) disable iff (!rstn_in)
		(kind == CBU_KIND_LTU) == (issue_in.insn[5:0] == 6'h36) && rf_idx_a_out == issue_in.insn[31:27])
		else $error("ltu decode wrong");

	a_opcode_ne: assert property (@(posedge clk_in) disable iff (!rstn_in)
		(kind == CBU_KIND_NE) == (issue_in.insn[5:0] == 6'h1e) && rf_idx_b_out == issue_in.insn[26:22])
		else $error("ne decode wrong");

	a_freeze_hold: assert property (@(posedge clk_in) disable iff (!rstn_in)
		!ce_in |=> $stable(result_out))
		else $error("state moved while frozen");

	// Reset empties the result, whatever the issue port shows
	a_reset_clears: assert property (@(posedge clk_in)
		!rstn_in
		|=> !result_out.valid && !result_out.taken && !result_out.misaligned
		&& result_out.next_pc == 32'h0)
		else $error("result not cleared by reset");

	// An instruction slot with valid low must not redirect the core
	a_idle_no_branch: assert property (@(posedge clk_in) disable iff (!rstn_in)
		!issue_in.valid && ce_in
		|=> !result_out.valid && !result_out.is_branch && !result_out.taken)
		else $error("idle slot produced a branch");

	// Any opcode but the two compare branches falls through
	a_other_falls: assert property (@(posedge clk_in) disable iff (!rstn_in)
		issue_in.valid && ce_in && issue_in.insn[5:0] != 6'h36 && issue_in.insn[5:0] != 6'h1e
		|=> result_out.valid && !result_out.is_branch && !result_out.taken
		&& result_out.next_pc == $past(issue_in.pc) + 32'h4)
		else $error("foreign opcode treated as branch");

	// Both opcodes are recognised as branches
	a_branch_flag: assert property (@(posedge clk_in) disable iff (!rstn_in)
		issue_in.valid && ce_in && (issue_in.insn[5:0] == 6'h36 || issue_in.insn[5:0] == 6'h1e)
		|=> result_out.valid && result_out.is_branch)
		else $error("branch opcode not flagged");

	// Distance from the following instruction to the target, seen one cycle on
	sequence s_offset_span;
		result_out.next_pc - $past(issue_in.pc) - 32'h4
			== {{16{$past(issue_in.insn[21])}}, $past(issue_in.insn[21:6])};
	endsequence

	// The offset counts from the instruction after the branch, sign extended
	a_ltu_offset_span: assert property (@(posedge clk_in) disable iff (!rstn_in)
		s_taken_ltu |=> s_offset_span)
		else $error("ltu displacement wrong");

	a_ne_offset_span: assert property (@(posedge clk_in) disable iff (!rstn_in)
		s_taken_ne |=> s_offset_span)
		else $error("ne displacement wrong");

	// Aligned pc plus aligned offset can never raise the exception
	sequence s_aligned_issue;
		issue_in.valid && ce_in && issue_in.pc[1:0] == 2'h0 && issue_in.insn[7:6] == 2'h0;
	endsequence

	a_aligned_quiet: assert property (@(posedge clk_in) disable iff (!rstn_in)
		s_aligned_issue |=> !result_out.misaligned)
		else $error("aligned target flagged");

	// A taken branch with offset low bits set lands off a word boundary
	a_misalign_raise: assert property (@(posedge clk_in) disable iff (!rstn_in)
		issue_in.valid && ce_in && issue_in.pc[1:0] == 2'h0 && issue_in.insn[7:6] != 2'h0
		&& ((kind == CBU_KIND_LTU && first_operand_reg_in < second_operand_reg_in)
		|| (kind == CBU_KIND_NE && first_operand_reg_in != second_operand_reg_in))
		|=> result_out.taken && result_out.misaligned)
		else $error("misaligned target not flagged");

	// Top bits differ: the unsigned order is set by the second operand's top bit alone
	a_ltu_unsigned: assert property (@(posedge clk_in) disable iff (!rstn_in)
		issue_in.valid && ce_in && kind == CBU_KIND_LTU
		&& first_operand_reg_in[31] != second_operand_reg_in[31]
		|=> result_out.taken == $past(second_operand_reg_in[31]))
		else $error("ltu compared as signed");

	// Operands equal below the top bit still differ as words
	a_ne_top_bit: assert property (@(posedge clk_in) disable iff (!rstn_in)
		issue_in.valid && ce_in && kind == CBU_KIND_NE
		&& first_operand_reg_in[30:0] == second_operand_reg_in[30:0]
		&& first_operand_reg_in[31] != second_operand_reg_in[31]
		|=> result_out.taken)
		else $error("ne ignored the top bit");

	// Register file indices follow the issued word in the same cycle
	a_index_fields: assert property (@(posedge clk_in) disable iff (!rstn_in)
		rf_idx_a_out == issue_in.insn[31:27] && rf_idx_b_out == issue_in.insn[26:22])
		else $error("register indices wrong");

	// Each enabled cycle hands back a result whose valid matches the issue valid of the cycle before
	a_valid_follows: assert property (@(posedge clk_in) disable iff (!rstn_in)
		ce_in |=> result_out.valid == $past(issue_in.valid))
		else $error("result valid out of step");
endmodule

// ---- test_cbu_branch_unit.sv ----
// Self-checking bench for the conditional branch unit
`timescale 1ns/1ps
module test_cbu_branch_unit;
	import cbu_pkg::*;
	logic clk_in = 1'b0;
	logic rstn_in = 1'b0;
	logic ce_in = 1'b1;
	cbu_issue_t issue_in = '0;
	logic [31:0] first_operand_reg_in = '0;
	logic [31:0] second_operand_reg_in = '0;
	cbu_result_t result_out;
	logic [4:0] rf_idx_a_out;
	logic [4:0] rf_idx_b_out;
	int miscompares = 0;
	int compares = 0;
	// 200 MHz core clock
	always #2.5 clk_in = ~clk_in;
	cbu_branch_unit cbu_branch_unit_i (
		.clk_in(clk_in),
		.rstn_in(rstn_in),
		.ce_in(ce_in),
		.issue_in(issue_in),
		.first_operand_reg_in(first_operand_reg_in),
		.second_operand_reg_in(second_operand_reg_in),
		.result_out(result_out),
		.rf_idx_a_out(rf_idx_a_out),
		.rf_idx_b_out(rf_idx_b_out)
	);
	// Four-state compare so an unknown never matches
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic complete_run();
		if (miscompares == 0 && compares > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// One issue at a falling edge, result judged one rising edge later
	task automatic one(input logic [31:0] pc, insn, ra, rb, input logic t, m, br);
		logic [31:0] tgt;
		tgt = pc + 32'h4 + {{16{insn[21]}}, insn[21:6]};
		issue_in = {1'b1, pc, insn};
		first_operand_reg_in = ra;
		second_operand_reg_in = rb;
		#1;
		chk("idx_a", 32'(rf_idx_a_out), 32'(insn[31:27]));
		chk("idx_b", 32'(rf_idx_b_out), 32'(insn[26:22]));
		@(posedge clk_in);
		@(negedge clk_in);
		chk("valid", 32'(result_out.valid), 32'h1);
		chk("is_branch", 32'(result_out.is_branch), 32'(br));
		chk("taken", 32'(result_out.taken), 32'(t));
		chk("next_pc", result_out.next_pc, t ? tgt : pc + 32'h4);
		chk("misaligned", 32'(result_out.misaligned), 32'(m));
	endtask
	// Unsigned compare: top bit set must count as large; offsets keep their low bits zero
	task automatic ltu_case();
		one(32'h1000, {5'h03, 5'h04, 16'h0010, CBU_OP_LTU}, 32'h1, 32'h80000000, 1'h1, 1'h0, 1'h1);
		one(32'h1004, {5'h1f, 5'h00, 16'h0010, CBU_OP_LTU}, 32'hffffffff, 32'h1, 1'h0, 1'h0, 1'h1);
		one(32'h1008, {5'h05, 5'h05, 16'h0010, CBU_OP_LTU}, 32'h7, 32'h7, 1'h0, 1'h0, 1'h1);
		one(32'h2000, {5'h01, 5'h02, 16'hfff0, CBU_OP_LTU}, 32'h0, 32'h2, 1'h1, 1'h0, 1'h1);
	endtask
	// Inequality on the top bit and on the bottom bit of the word
	task automatic ne_case();
		one(32'h3000, {5'h06, 5'h07, 16'h0100, CBU_OP_NE}, 32'h0, 32'h80000000, 1'h1, 1'h0, 1'h1);
		one(32'h3004, {5'h08, 5'h09, 16'h0100, CBU_OP_NE}, 32'h5a5a5a5a, 32'h5a5a5a5a, 1'h0, 1'h0, 1'h1);
		one(32'h0010, {5'h0a, 5'h0b, 16'h8000, CBU_OP_NE}, 32'h1, 32'h0, 1'h1, 1'h0, 1'h1);
	endtask
	// Bad offset low bits flag only when the branch is taken
	task automatic misalign_case();
		one(32'h4000, {5'h01, 5'h02, 16'h0002, CBU_OP_LTU}, 32'h0, 32'h1, 1'h1, 1'h1, 1'h1);
		one(32'h4004, {5'h01, 5'h02, 16'h0001, CBU_OP_NE}, 32'h3, 32'h3, 1'h0, 1'h0, 1'h1);
		one(32'h4008, {5'h01, 5'h02, 16'h0003, CBU_OP_NE}, 32'h3, 32'h4, 1'h1, 1'h1, 1'h1);
	endtask
	// Reset in mid-run clears a flagged result while an issue is still held
	task automatic reset_case();
		rstn_in = 1'h0;
		repeat (2) @(negedge clk_in);
		chk("reset valid", 32'(result_out.valid), 32'h0);
		chk("reset next_pc", result_out.next_pc, 32'h0);
		chk("reset misaligned", 32'(result_out.misaligned), 32'h0);
		rstn_in = 1'h1;
	endtask
	// Valid low: no result slot and no redirect, even for a branch word
	task automatic idle_case();
		issue_in = {1'h0, 32'h8000, {5'h01, 5'h02, 16'h0010, CBU_OP_NE}};
		first_operand_reg_in = 32'h1;
		second_operand_reg_in = 32'h2;
		@(negedge clk_in);
		chk("idle valid", 32'(result_out.valid), 32'h0);
		chk("idle is_branch", 32'(result_out.is_branch), 32'h0);
		chk("idle taken", 32'(result_out.taken), 32'h0);
		chk("idle next_pc", result_out.next_pc, 32'h8004);
	endtask
	// Enable low: a fresh issue is ignored and the last result stays put
	task automatic freeze_case();
		one(32'h6000, {5'h01, 5'h02, 16'h0020, CBU_OP_NE}, 32'h1, 32'h2, 1'h1, 1'h0, 1'h1);
		ce_in = 1'h0;
		issue_in = {1'h1, 32'h7000, {5'h01, 5'h02, 16'h0040, CBU_OP_LTU}};
		first_operand_reg_in = 32'h0;
		second_operand_reg_in = 32'h9;
		repeat (2) @(negedge clk_in);
		chk("frozen next_pc", result_out.next_pc, 32'h6024);
		chk("frozen taken", 32'(result_out.taken), 32'h1);
		ce_in = 1'h1;
		@(negedge clk_in);
		chk("thawed next_pc", result_out.next_pc, 32'h7044);
	endtask
	// Neighbouring opcode is not one of ours
	task automatic other_case();
		one(32'h5000, {5'h01, 5'h02, 16'h0010, 6'h16}, 32'h0, 32'h1, 1'h0, 1'h0, 1'h0);
	endtask
	initial begin
		repeat (10) @(negedge clk_in);
		chk("reset next_pc", result_out.next_pc, 32'h0);
		chk("reset misaligned", 32'(result_out.misaligned), 32'h0);
		rstn_in = 1'b1;
		ltu_case();
		ne_case();
		misalign_case();
		reset_case();
		idle_case();
		freeze_case();
		other_case();
		complete_run();
	end
endmodule
